// >>> dv/dac_level_code_calibration_chk.sv
// checker: bus answer timing and control word loads at the ports
// assumes it is bound to the trim block and sees only its ports
module level_trim_chk (
   input wire logic        i_clk,
   input wire logic        i_resetn,
   input wire logic [7:0]  i_address,
   input wire logic        i_read,
   input wire logic        i_write,
   input wire logic [31:0] i_writedata,
   input wire logic [3:0]  i_byteenable,
   input wire logic [31:0] o_readdata,
   input wire logic        o_waitrequest,
   input wire logic [15:0] o_open_sense_threshold,
   input wire logic [15:0] o_ground_sense_limit,
   input wire logic [15:0] o_offset_code,
   input wire logic [2:0]  o_range,
   input wire logic        o_load_current_amp_gain20
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ==========================================================
   // accepted writes, decoded per register
   wire wr_ok   = i_write && !o_waitrequest;
   wire ctrl_wr = wr_ok && i_address == 8'h00 && i_byteenable[0];
   wire ofs_wr  = wr_ok && i_address == 8'h20;
   wire osd_wr  = wr_ok && i_address == 8'h18;

   // a fresh request waits two cycles, then gets its answer
   sequence req_start;
      $rose(i_read || i_write);
   endsequence
   sequence answer_wait;
      o_waitrequest [*2] ##1 !o_waitrequest;
   endsequence

   // ==========================================================
   // bus timing and readback width
   chk_answer_time: assert property (req_start |-> answer_wait)
      else $error("bus answer not on third edge");
   chk_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
      else $error("waitrequest low longer than one cycle");
   chk_read_upper: assert property (
      i_read && !o_waitrequest && i_address != 8'h24
      |-> o_readdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");

   // ==========================================================
   // control word follows its writes only; offset and open sense words load on write, sense levels hold across offset writes
   chk_range_load: assert property (
      ctrl_wr |=> o_range == $past(i_writedata[2:0]))
      else $error("range not loaded from control write");
   chk_gain_load: assert property (
      ctrl_wr |=> o_load_current_amp_gain20 == $past(i_writedata[4]))
      else $error("gain select not loaded");
   chk_range_hold: assert property (
      !ctrl_wr |=> $stable(o_range) && $stable(o_load_current_amp_gain20))
      else $error("range changed without control write");
   chk_offset_load: assert property (
      ofs_wr |=> o_offset_code == $past(i_writedata[15:0]))
      else $error("offset word not loaded");
   chk_sense_isol: assert property (
      ofs_wr |=> $stable(o_open_sense_threshold)
                 && $stable(o_ground_sense_limit))
      else $error("offset write moved a sense level");
   chk_osd_load: assert property (
      osd_wr |=> o_open_sense_threshold == $past(i_writedata[15:0]))
      else $error("open sense word not loaded");
endmodule

bind dac_level_code_calibration level_trim_chk u_chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_address(i_address),
   .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
   .i_byteenable(i_byteenable), .o_readdata(o_readdata),
   .o_waitrequest(o_waitrequest),
   .o_open_sense_threshold(o_open_sense_threshold),
   .o_ground_sense_limit(o_ground_sense_limit),
   .o_offset_code(o_offset_code), .o_range(o_range),
   .o_load_current_amp_gain20(o_load_current_amp_gain20)
);

// >>> dv/level_host_model.sv
// host model: avalon-mm master writing level and trim words
// assumes a slave that drops waitrequest for one cycle per access
module level_host_model (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_readdata,
   input  wire logic        i_waitrequest,
   output logic      [7:0]  o_address,
   output logic             o_read,
   output logic             o_write,
   output logic      [31:0] o_writedata,
   output logic      [3:0]  o_byteenable
);
   timeunit 1ns;
   timeprecision 1ns;

   // ==========================================================
   // idle bus at time zero
   initial begin
      o_address    = 8'h00;
      o_read       = 1'b0;
      o_write      = 1'b0;
      o_writedata  = 32'h0000_0000;
      o_byteenable = 4'hF;
   end

   // one access; request held until waitrequest is sampled low
   // any slope word is sent as given, quarter scale too
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [15:0] d, output logic [31:0] q);
      @(posedge i_clk);
      o_address   <= a;
      o_writedata <= {16'h0000, d};
      o_write     <= w;
      o_read      <= !w;
      // no cycle limit of its own: only the bench watchdog ends a wait
      do begin
         @(posedge i_clk);
      end while (i_waitrequest);
      q = i_readdata;
      o_read  <= 1'b0;
      o_write <= 1'b0;
   endtask
endmodule

// >>> dv/tb_dac_level_code_calibration.sv
// testbench: trim arithmetic, trim set selection and reset defaults
// assumes the host model as bus master and a 10 MHz clock
module tb_dac_level_code_calibration;
   timeunit 1ns;
   timeprecision 1ns;

   logic i_clk, i_resetn, read, write, waitrequest, gain20;
   logic [7:0]  address;
   logic [3:0]  byteenable;
   logic [31:0] writedata, readdata, q;
   logic [17:0] force_code;
   logic [15:0] cmp_hi, cmp_lo, clamp_hi, clamp_lo, open_sense_threshold, gsl, ofs;
   logic [2:0]  range;
   logic [7:0]  wa, ra;
   logic [15:0] wd;
   logic [23:0] ex;
   int mismatches = 0;
   int check_count = 0;

   // ==========================================================
   // rows: write address, write data, read address, expected
   logic [55:0] rows [0:10] = '{
      {8'h04, 16'h1234, 8'h04, 24'h00_1234},
      {8'hC8, 16'hBEEF, 8'hC8, 24'h00_0000},
      {8'h24, 16'h0000, 8'h24, 24'h00_48D0},
      {8'h80, 16'h4000, 8'h24, 24'h00_1234},
      {8'h84, 16'h0000, 8'h24, 24'h00_0000},
      {8'h84, 16'hFFFF, 8'h24, 24'h02_1230},
      {8'h14, 16'hFFFF, 8'h34, 24'h00_FFFF},
      {8'h8C, 16'hFFFF, 8'h34, 24'h00_FFFF},
      {8'h10, 16'h0000, 8'h30, 24'h00_7FFF},
      {8'h20, 16'h1111, 8'h20, 24'h00_1111},
      {8'h18, 16'hABCD, 8'h18, 24'h00_ABCD}};

   // ==========================================================
   // clock, design and host
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   dac_level_code_calibration u_dac_level_code_calibration (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_address(address),
      .i_read(read), .i_write(write), .i_writedata(writedata),
      .i_byteenable(byteenable), .o_readdata(readdata),
      .o_waitrequest(waitrequest), .o_force_code(force_code),
      .o_cmp_hi_code(cmp_hi), .o_cmp_lo_code(cmp_lo),
      .o_clamp_hi_code(clamp_hi), .o_clamp_lo_code(clamp_lo),
      .o_open_sense_threshold(open_sense_threshold), .o_ground_sense_limit(gsl),
      .o_offset_code(ofs), .o_range(range),
      .o_load_current_amp_gain20(gain20));

   level_host_model u_level_host_model (
      .i_clk(i_clk), .i_readdata(readdata), .i_waitrequest(waitrequest),
      .o_address(address), .o_read(read), .o_write(write),
      .o_writedata(writedata), .o_byteenable(byteenable));

   // ==========================================================
   // compare, bus shortcuts and verdict
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] unused;
      u_level_host_model.xfer(1'b1, a, d, unused);
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ==========================================================
   // main sequence; 20 idle cycles exceed the 15-cycle refresh
   initial begin
      i_resetn = 1'b0;
      repeat (6) @(posedge i_clk);
      i_resetn <= 1'b1;
      for (int k = 0; k < 11; k++) begin
         {wa, wd, ra, ex} = rows[k];
         wr(wa, wd);
         repeat (20) @(posedge i_clk);
         u_level_host_model.xfer(1'b0, ra, 16'h0000, q);
         if (ra == 8'h24)
            cmp({14'h0000, force_code}, {8'h00, ex});
         else
            cmp(q, {8'h00, ex});
      end
      cmp({16'h0000, open_sense_threshold}, 32'h0000_ABCD);
      cmp({16'h0000, gsl}, 32'h0000_0000);
      cmp({16'h0000, clamp_hi}, 32'h0000_7FFF);
      cmp({16'h0000, clamp_lo}, 32'h0000_FFFF);
      // ground-sense word passes untrimmed and leaves the others alone
      wr(8'h1C, 16'h2468);
      @(posedge i_clk);
      cmp({16'h0000, gsl}, 32'h0000_2468);
      cmp({16'h0000, open_sense_threshold}, 32'h0000_ABCD);
      cmp({16'h0000, ofs}, 32'h0000_1111);
      $display("table test done");
      // each range gets its own bias; range 7 falls back to range 6
      wr(8'h08, 16'h1000);
      for (int r = 0; r < 7; r++)
         wr(8'h94 + 8'(8 * r), 16'h8000 + 16'(16 * r));
      for (int r = 0; r < 8; r++) begin
         wr(8'h00, {11'h000, r[0], 1'b0, r[2:0]});
         repeat (20) @(posedge i_clk);
         u_level_host_model.xfer(1'b0, 8'h28, 16'h0000, q);
         cmp(q, 32'h0000_1000 + 32'(16 * (r > 6 ? 6 : r)));
         cmp({16'h0000, cmp_lo}, 32'(16 * (r > 6 ? 6 : r)));
         cmp({29'h0000_0000, range}, 32'(r));
         cmp({31'h0000_0000, gain20}, 32'(r % 2));
      end
      $display("range test done");
      // reset in mid-run brings back unity trim
      i_resetn <= 1'b0;
      repeat (6) @(posedge i_clk);
      cmp({16'h0000, ofs}, 32'h0000_8000);
      i_resetn <= 1'b1;
      u_level_host_model.xfer(1'b0, 8'h80, 16'h0000, q);
      cmp(q, 32'h0000_FFFF);
      u_level_host_model.xfer(1'b0, 8'h88, 16'h0000, q);
      cmp(q, 32'h0000_FFFF);
      u_level_host_model.xfer(1'b0, 8'h84, 16'h0000, q);
      cmp(q, 32'h0000_8000);
      u_level_host_model.xfer(1'b0, 8'h94, 16'h0000, q);
      cmp(q, 32'h0000_8000);
      $display("reset test done");
      summarize();
   end

   // watchdog: the tests need well under 2000 cycles
   initial begin
      #1_000_000;
      mismatches++;
      summarize();
   end
endmodule

// >>> inc/dac_trim_map.vh
// register map, field positions, reset values and trim-store layout
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
`ifndef DAC_TRIM_MAP_VH
`define DAC_TRIM_MAP_VH

// ==================================================================
// register byte addresses
`define OFS_CTRL        8'h00
`define OFS_FORCE_RAW   8'h04
`define OFS_CMPH_RAW    8'h08
`define OFS_CMPL_RAW    8'h0C
`define OFS_CLMH_RAW    8'h10
`define OFS_CLML_RAW    8'h14
`define OFS_OSD_RAW     8'h18
`define OFS_DGS_RAW     8'h1C
`define OFS_OFFSET      8'h20
`define OFS_FORCE_TRIM  8'h24
`define OFS_CMPH_TRIM   8'h28
`define OFS_CMPL_TRIM   8'h2C
`define OFS_CLMH_TRIM   8'h30
`define OFS_CLML_TRIM   8'h34
// trim store window: byte address 0x80 + 4 * entry index
`define TRIM_AREA_BIT   7

// ==================================================================
// control register fields
`define CTRL_RANGE_LSB  0
`define CTRL_RANGE_MSB  2
`define CTRL_GAIN20_BIT 4
`define RANGE_LAST      3'h6

// ==================================================================
// trim store entries: slope at even index, bias at the odd one after
`define TRIM_FORCE_IDX  5'h00
`define TRIM_CLAMP_IDX  5'h02
`define TRIM_CMP_IDX    5'h04
`define TRIM_ENTRIES    5'h12

// ==================================================================
// reset values and arithmetic constants
`define SLOPE_RST       16'hFFFF
`define BIAS_RST        16'h8000
`define OFFSET_RST      16'h8000
`define HALF_SCALE_16   21'h00_8000
`define HALF_SCALE_18   21'h02_0000
`define MAX_CODE_16     16'hFFFF
`define MAX_CODE_18     18'h3_FFFF

`endif

// >>> rtl/dac_level_code_calibration.v
// level word trim path: raw level words in, corrected converter codes out
// assumes an avalon-mm master with waitrequest and a 10 MHz i_clk
// the converter array samples the o_*_code outputs at any time
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.

// Operation
// - trimmed = raw*(slope+1)/2^16 + bias - half
// - raw level words are 16-bit registers
// - slope words reset to all ones
// - bias words reset to midscale
// - force level has one trim set
// - comparators use seven range-selected trim sets
// - clamps share one trim set everywhere
// - clamp raw, slope, bias are 16 bit
// - offset shifts force, comparator, clamp only
// - force path keeps 18 bits internally
// - load current amp gain is 10 or 20
module dac_level_code_calibration (
   input  wire        i_clk,
   input  wire        i_resetn,
   input  wire [7:0]  i_address,
   input  wire        i_read,
   input  wire        i_write,
   input  wire [31:0] i_writedata,
   input  wire [3:0]  i_byteenable,
   output reg  [31:0] o_readdata,
   output wire        o_waitrequest,
   output reg  [17:0] o_force_code,
   output reg  [15:0] o_cmp_hi_code,
   output reg  [15:0] o_cmp_lo_code,
   output reg  [15:0] o_clamp_hi_code,
   output reg  [15:0] o_clamp_lo_code,
   output wire [15:0] o_open_sense_threshold,
   output wire [15:0] o_ground_sense_limit,
   output wire [15:0] o_offset_code,
   output wire [2:0]  o_range,
   output wire        o_load_current_amp_gain20
);
`include "dac_trim_map.vh"

   // bus phases: accept, fetch, answer
   localparam [1:0] PH_IDLE  = 2'd0;
   localparam [1:0] PH_FETCH = 2'd1;
   localparam [1:0] PH_DONE  = 2'd2;
   // engine steps: address slope, address bias, compute
   localparam [1:0] ST_SLOPE = 2'd0;
   localparam [1:0] ST_BIAS  = 2'd1;
   localparam [1:0] ST_CALC  = 2'd2;
   localparam [2:0] CH_FORCE = 3'd0;
   localparam [2:0] CH_CMPH  = 3'd1;
   localparam [2:0] CH_CMPL  = 3'd2;
   localparam [2:0] CH_CLMH  = 3'd3;
   localparam [2:0] CH_LAST  = 3'd4;

   // ===============================================================
   // functions
   // merge the two low byte lanes of a write into a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  be;
      begin
         merge16 = {be[1] ? wd[15:8] : old[15:8],
                    be[0] ? wd[7:0]  : old[7:0]};
      end
   endfunction

   // clamp a signed 21-bit sum into 0..65535
   function [15:0] sat16;
      input [20:0] v;
      begin
         if (v[20]) begin
            sat16 = 16'h0000;
         end else if (v[19:16] != 4'h0) begin
            sat16 = `MAX_CODE_16;
         end else begin
            sat16 = v[15:0];
         end
      end
   endfunction

   // clamp a signed 21-bit sum into the 18-bit force code range
   function [17:0] sat18;
      input [20:0] v;
      begin
         if (v[20]) begin
            sat18 = 18'h0_0000;
         end else if (v[19:18] != 2'b00) begin
            sat18 = `MAX_CODE_18;
         end else begin
            sat18 = v[17:0];
         end
      end
   endfunction

   // slope entry of the trim set a channel uses in the given range
   function [4:0] trim_base;
      input [2:0] ch;
      input [2:0] rng;
      reg   [2:0] r;
      begin
         r = (rng > `RANGE_LAST) ? `RANGE_LAST : rng;
         case (ch)
            CH_FORCE: trim_base = `TRIM_FORCE_IDX;
            CH_CMPH,
            CH_CMPL:  trim_base = `TRIM_CMP_IDX + {1'b0, r, 1'b0};
            default:  trim_base = `TRIM_CLAMP_IDX;
         endcase
      end
   endfunction

   // ===============================================================
   // registers
   reg [1:0]  phase_r;
   reg [2:0]  range_r;
   reg        gain20_r;
   reg [15:0] force_raw_r;
   reg [15:0] cmph_raw_r;
   reg [15:0] cmpl_raw_r;
   reg [15:0] clmh_raw_r;
   reg [15:0] clml_raw_r;
   reg [15:0] osd_raw_r;
   reg [15:0] dgs_raw_r;
   reg [15:0] offset_r;
   reg [1:0]  step_r;
   reg [2:0]  chan_r;
   reg [15:0] slope_r;
   reg [4:0]  eng_addr;
   reg [15:0] raw_sel;
   reg [31:0] rd_val;

   wire        bus_req   = i_read | i_write;
   wire        trim_hit  = i_address[`TRIM_AREA_BIT] &
                           (i_address[6:2] < `TRIM_ENTRIES);
   wire        reg_write = i_write & (phase_r == PH_DONE);
   wire [4:0]  mem_addr  = bus_req ? i_address[6:2] : eng_addr;
   wire [15:0] mem_data;
   wire [32:0] prod;
   wire [20:0] sum16;
   wire [20:0] sum18;

   // ===============================================================
   // bus slave
   // every access takes three cycles so trim-store reads answer from
   // a register like all the others; the master must hold its request
   assign o_waitrequest = (phase_r != PH_DONE);

   always @(posedge i_clk) begin
      if (!i_resetn) begin
         phase_r <= PH_IDLE;
      end else begin
         case (phase_r)
            PH_IDLE:  phase_r <= bus_req ? PH_FETCH : PH_IDLE;
            PH_FETCH: phase_r <= PH_DONE;
            PH_DONE:  phase_r <= PH_IDLE;
            default:  phase_r <= PH_IDLE;
         endcase
      end
   end

   // read mux; unmapped addresses read zero
   always @* begin
      rd_val = 32'h0000_0000;
      if (i_address[`TRIM_AREA_BIT]) begin
         if (trim_hit) begin
            rd_val = {16'h0000, mem_data};
         end
      end else begin
         case (i_address)
            `OFS_CTRL: begin
               rd_val[`CTRL_RANGE_MSB:`CTRL_RANGE_LSB] = range_r;
               rd_val[`CTRL_GAIN20_BIT] = gain20_r;
            end
            `OFS_FORCE_RAW:  rd_val = {16'h0000, force_raw_r};
            `OFS_CMPH_RAW:   rd_val = {16'h0000, cmph_raw_r};
            `OFS_CMPL_RAW:   rd_val = {16'h0000, cmpl_raw_r};
            `OFS_CLMH_RAW:   rd_val = {16'h0000, clmh_raw_r};
            `OFS_CLML_RAW:   rd_val = {16'h0000, clml_raw_r};
            `OFS_OSD_RAW:    rd_val = {16'h0000, osd_raw_r};
            `OFS_DGS_RAW:    rd_val = {16'h0000, dgs_raw_r};
            `OFS_OFFSET:     rd_val = {16'h0000, offset_r};
            `OFS_FORCE_TRIM: rd_val = {14'h0000, o_force_code};
            `OFS_CMPH_TRIM:  rd_val = {16'h0000, o_cmp_hi_code};
            `OFS_CMPL_TRIM:  rd_val = {16'h0000, o_cmp_lo_code};
            `OFS_CLMH_TRIM:  rd_val = {16'h0000, o_clamp_hi_code};
            `OFS_CLML_TRIM:  rd_val = {16'h0000, o_clamp_lo_code};
            default:         rd_val = 32'h0000_0000;
         endcase
      end
   end

   // read data is caught in the fetch phase and stands while answered
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_readdata <= 32'h0000_0000;
      end else if (i_read && phase_r == PH_FETCH) begin
         o_readdata <= rd_val;
      end
   end

   // level and control registers, written on the answering edge
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         range_r     <= 3'h0;
         gain20_r    <= 1'b0;
         force_raw_r <= 16'h0000;
         cmph_raw_r  <= 16'h0000;
         cmpl_raw_r  <= 16'h0000;
         clmh_raw_r  <= 16'h0000;
         clml_raw_r  <= 16'h0000;
         osd_raw_r   <= 16'h0000;
         dgs_raw_r   <= 16'h0000;
         offset_r    <= `OFFSET_RST;
      end else if (reg_write) begin
         case (i_address)
            `OFS_CTRL: begin
               if (i_byteenable[0]) begin
                  range_r  <= i_writedata[`CTRL_RANGE_MSB:
                                          `CTRL_RANGE_LSB];
                  gain20_r <= i_writedata[`CTRL_GAIN20_BIT];
               end
            end
            `OFS_FORCE_RAW: force_raw_r <= merge16(force_raw_r,
                               i_writedata, i_byteenable);
            `OFS_CMPH_RAW:  cmph_raw_r <= merge16(cmph_raw_r,
                               i_writedata, i_byteenable);
            `OFS_CMPL_RAW:  cmpl_raw_r <= merge16(cmpl_raw_r,
                               i_writedata, i_byteenable);
            `OFS_CLMH_RAW:  clmh_raw_r <= merge16(clmh_raw_r,
                               i_writedata, i_byteenable);
            `OFS_CLML_RAW:  clml_raw_r <= merge16(clml_raw_r,
                               i_writedata, i_byteenable);
            `OFS_OSD_RAW:   osd_raw_r <= merge16(osd_raw_r,
                               i_writedata, i_byteenable);
            `OFS_DGS_RAW:   dgs_raw_r <= merge16(dgs_raw_r,
                               i_writedata, i_byteenable);
            `OFS_OFFSET:    offset_r <= merge16(offset_r,
                               i_writedata, i_byteenable);
            default: ;
         endcase
      end
   end

   // ===============================================================
   // trim store; the bus owns its port whenever a request is up
   trim_store u_trim_store (
      .i_clk     (i_clk),
      .i_resetn  (i_resetn),
      .i_wr_en   (reg_write & trim_hit),
      .i_wr_addr (i_address[6:2]),
      .i_wr_data (merge16(mem_data, i_writedata, i_byteenable)),
      .i_rd_addr (mem_addr),
      .o_rd_data (mem_data)
   );

   // ===============================================================
   // calibration engine
   // one shared multiplier visits the five trimmed levels in turn;
   // area is traded for a refresh of every level within 15 idle cycles
   always @* begin
      eng_addr = trim_base(chan_r, range_r);
      if (step_r == ST_BIAS) begin
         eng_addr = trim_base(chan_r, range_r) + 5'd1;
      end
   end

   always @* begin
      case (chan_r)
         CH_FORCE: raw_sel = force_raw_r;
         CH_CMPH:  raw_sel = cmph_raw_r;
         CH_CMPL:  raw_sel = cmpl_raw_r;
         CH_CLMH:  raw_sel = clmh_raw_r;
         default:  raw_sel = clml_raw_r;
      endcase
   end

   // full-width product so a quarter-scale slope keeps resolution
   assign prod  = {17'h0_0000, raw_sel}
                  * {16'h0000, {1'b0, slope_r} + 17'h0_0001};
   assign sum16 = {4'h0, prod[32:16]} + {5'h00, mem_data}
                  - `HALF_SCALE_16;
   assign sum18 = {2'b00, prod[32:14]} + {3'b000, mem_data, 2'b00}
                  - `HALF_SCALE_18;

   // a step whose port was taken by the bus restarts the channel,
   // since the registered read data no longer belongs to it
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         step_r  <= ST_SLOPE;
         chan_r  <= CH_FORCE;
         slope_r <= `SLOPE_RST;
      end else begin
         case (step_r)
            ST_SLOPE: begin
               if (!bus_req) begin
                  step_r <= ST_BIAS;
               end
            end
            ST_BIAS: begin
               if (!bus_req) begin
                  slope_r <= mem_data;
                  step_r  <= ST_CALC;
               end else begin
                  step_r  <= ST_SLOPE;
               end
            end
            ST_CALC: begin
               step_r <= ST_SLOPE;
               chan_r <= (chan_r == CH_LAST) ? CH_FORCE : chan_r + 3'd1;
            end
            default: step_r <= ST_SLOPE;
         endcase
      end
   end

   // trimmed codes, saturated rather than wrapped
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         o_force_code    <= 18'h0_0000;
         o_cmp_hi_code   <= 16'h0000;
         o_cmp_lo_code   <= 16'h0000;
         o_clamp_hi_code <= 16'h0000;
         o_clamp_lo_code <= 16'h0000;
      end else if (step_r == ST_CALC) begin
         case (chan_r)
            CH_FORCE: o_force_code    <= sat18(sum18);
            CH_CMPH:  o_cmp_hi_code   <= sat16(sum16);
            CH_CMPL:  o_cmp_lo_code   <= sat16(sum16);
            CH_CLMH:  o_clamp_hi_code <= sat16(sum16);
            default:  o_clamp_lo_code <= sat16(sum16);
         endcase
      end
   end

   // ===============================================================
   // pass-through levels
   // the offset code goes only to the force, comparator and clamp
   // converters; threshold and ground-sense levels never see it
   assign o_offset_code          = offset_r;
   assign o_open_sense_threshold = osd_raw_r;
   assign o_ground_sense_limit   = dgs_raw_r;
   assign o_range                = range_r;
   assign o_load_current_amp_gain20 = gain20_r;

endmodule

// >>> rtl/trim_store.v
// slope and bias store for all trim sets, one 16-bit word per entry
// assumes one writer and one reader per clock; read data is registered
module trim_store (
   input  wire        i_clk,
   input  wire        i_resetn,
   input  wire        i_wr_en,
   input  wire [4:0]  i_wr_addr,
   input  wire [15:0] i_wr_data,
   input  wire [4:0]  i_rd_addr,
   output wire [15:0] o_rd_data
);
`include "dac_trim_map.vh"

   reg [15:0] mem [0:31];
   reg [31:0] written_r;
   reg [15:0] rd_data_r;

   // ===============================================================
   // storage
   // array itself has no reset; written flags stand in for the
   // defaults so no reset loop over 32 words is needed
   always @(posedge i_clk) begin
      if (i_wr_en) begin
         mem[i_wr_addr] <= i_wr_data;
      end
   end

   // unwritten slope reads all ones, unwritten bias reads midscale
   always @(posedge i_clk) begin
      if (!i_resetn) begin
         written_r <= 32'h0000_0000;
         rd_data_r <= 16'h0000;
      end else begin
         if (i_wr_en) begin
            written_r[i_wr_addr] <= 1'b1;
         end
         if (written_r[i_rd_addr]) begin
            rd_data_r <= mem[i_rd_addr];
         end else if (i_rd_addr[0]) begin
            rd_data_r <= `BIAS_RST;
         end else begin
            rd_data_r <= `SLOPE_RST;
         end
      end
   end

   assign o_rd_data = rd_data_r;

endmodule
